// ---- hdl/bfp_pkg.sv ----
package bfp_pkg;
  // register map, byte addresses on a 32-bit apb
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_PHASE_THR   = 8'h04;
  localparam logic [7:0]  OFF_RES_THR     = 8'h08;
  localparam logic [7:0]  OFF_RETRIP_DLY  = 8'h0C;
  localparam logic [7:0]  OFF_FAIL_DLY    = 8'h10;
  localparam logic [7:0]  OFF_SIG_MASK    = 8'h14;
  localparam logic [7:0]  OFF_RELAY_MASK  = 8'h18;
  localparam logic [7:0]  OFF_STATUS      = 8'h1C;
  // ctrl field positions
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_RES_LSB    = 4;
  localparam int          CTRL_RETRIP_BIT = 6;
  localparam int          CTRL_FORCE_BIT  = 7;
  localparam int          CTRL_FSTAT_LSB  = 8;
  // status field positions
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_PU_LSB     = 5;
  localparam int          STAT_START_BIT  = 9;
  // widths
  localparam int          MAG_W           = 16;
  localparam int          PTHR_W          = 12;
  localparam int          DLY_W           = 19;
  localparam int          PROD_W          = 24;
  // operating modes
  typedef enum logic [3:0] {
    MODE_CUR              = 4'h0,
    MODE_DO               = 4'h1,
    MODE_SIG              = 4'h2,
    MODE_CUR_AND_DO       = 4'h3,
    MODE_CUR_AND_SIG      = 4'h4,
    MODE_CUR_OR_SIG       = 4'h5,
    MODE_SIG_AND_DO       = 4'h6,
    MODE_SIG_OR_DO        = 4'h7,
    MODE_CUR_OR_DO        = 4'h8,
    MODE_CUR_OR_SIG_AND_DO = 4'h9,
    MODE_CUR_OR_DO_OR_SIG = 4'hA,
    MODE_CUR_AND_DO_AND_SIG = 4'hB
  } mode_t;
  typedef enum logic [1:0] {
    RES_UNUSED = 2'h0,
    RES_ONE    = 2'h1,
    RES_TWO    = 2'h2,
    RES_CALC   = 2'h3
  } res_sel_t;
  typedef enum logic [4:0] {
    ST_NORMAL  = 5'h01,
    ST_START   = 5'h02,
    ST_RETRIP  = 5'h04,
    ST_FAIL    = 5'h08,
    ST_BLOCKED = 5'h10
  } state_t;
  localparam logic [2:0]  FORCE_NORMAL    = 3'h0;
  localparam logic [2:0]  FORCE_START     = 3'h1;
  localparam logic [2:0]  FORCE_RETRIP    = 3'h2;
  localparam logic [2:0]  FORCE_FAIL      = 3'h3;
  localparam logic [2:0]  FORCE_BLOCKED   = 3'h4;
  // reset values: thresholds in 0.01 / 0.001 x nominal, delays in ticks
  localparam logic [PTHR_W-1:0] PTHR_RST  = 12'h014;
  localparam logic [MAG_W-1:0]  RTHR_RST  = 16'h04B0;
  localparam logic [DLY_W-1:0]  RETRIP_RST = 19'h00014;
  localparam logic [DLY_W-1:0]  FAIL_RST  = 19'h00028;
  // scaling and timing
  localparam int          PTHR_SCALE      = 10;
  localparam int          HYST_PCT        = 97;
  localparam int          PCT_FULL        = 100;
  localparam int          CLK_HZ          = 40000000;
  localparam int          TICK_MS         = 5;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
endpackage

// ---- hdl/breaker_failure_protection.sv ----
// Notes on behaviour
// - supervise breaker after trip; failed retrip raises breaker-failure output
// - retrip can be disabled; then no retrip output at all
// - triggers are current, output relays, binary signals, or combinations
// - three phase magnitudes and selected residual evaluated continuously
// - any selected internal binary signal can start the countdown
// - selected output relay control state acts as a trigger
// - comparators see fundamental-frequency magnitudes only
// - residual source is unused, input one, input two or calculated; default unused
// - monitoring and forcing settings are static, not tied to setting group
// - selected trip signals count only when mode includes signals
// - selected relays count only when mode includes output monitoring
// - status forcing to five states, only while stage forcing is enabled
// - pick-up when any phase, or selected residual, exceeds its threshold
// - pick-up releases below 97 percent of the threshold
// - one phase threshold applies to all three phases
// - new operating settings apply immediately while running
// - mode selector combines criteria with and/or; default current only
// - phase threshold 0.01 to 40.00 in 0.01 steps, default 0.20
// - residual threshold 0.005 to 40.000 in 0.001 steps, default 1.200
// - retrip after retrip delay, failure after failure delay, same start
// - both counters clear as soon as the start condition drops
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_protection
  import bfp_pkg::*;
#(
  parameter int SIG_W       = 16,
  parameter int RELAY_W     = 8,
  parameter int TICK_CYC    = bfp_pkg::TICK_CYCLES
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bfp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic [bfp_pkg::MAG_W-1:0]   phase_mag_a,
  input  wire logic [bfp_pkg::MAG_W-1:0]   phase_mag_b,
  input  wire logic [bfp_pkg::MAG_W-1:0]   phase_mag_c,
  input  wire logic [bfp_pkg::MAG_W-1:0]   residual_input_one,
  input  wire logic [bfp_pkg::MAG_W-1:0]   residual_input_two,
  input  wire logic [bfp_pkg::MAG_W-1:0]   calculated_residual,
  input  wire logic [SIG_W-1:0]            trip_signals,
  input  wire logic [RELAY_W-1:0]          relay_controls,
  output var  logic                        start_out,
  output var  logic                        retrip_out,
  output var  logic                        breaker_failure_output,
  output var  logic                        blocked_out
);
  import bfp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register file
  mode_t               mode;
  res_sel_t            residual_source_select;
  logic                retrip_en;
  logic                force_en;
  logic [2:0]          force_stat;
  logic [PTHR_W-1:0]   phase_pickup_threshold;
  logic [MAG_W-1:0]    residual_pickup_threshold;
  logic [DLY_W-1:0]    retrip_dly;
  logic [DLY_W-1:0]    fail_dly;
  logic [SIG_W-1:0]    sig_mask;
  logic [RELAY_W-1:0]  relay_mask;
  mode_t               next_mode;
  res_sel_t            next_res_sel;
  logic                next_retrip_en;
  logic                next_force_en;
  logic [2:0]          next_force_stat;
  logic [PTHR_W-1:0]   next_pthr;
  logic [MAG_W-1:0]    next_rthr;
  logic [DLY_W-1:0]    next_retrip_dly;
  logic [DLY_W-1:0]    next_fail_dly;
  logic [SIG_W-1:0]    next_sig_mask;
  logic [RELAY_W-1:0]  next_relay_mask;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  logic                wr;
  logic                rd_hit;
  logic [31:0]         rd_val;
  logic [31:0]         stat_word;
  state_t              state;
  logic [3:0]          pu;
  logic                start_cond;

  assign wr = psel && penable && pready && pwrite;

  always_comb begin
    stat_word = '0;
    stat_word[STAT_STATE_LSB +: 5] = state;
    stat_word[STAT_PU_LSB +: 4] = pu;
    stat_word[STAT_START_BIT] = start_cond;
  end

  // settings are plain registers: a write takes effect on the next cycle
  always_comb begin
    next_mode       = mode;
    next_res_sel    = residual_source_select;
    next_retrip_en  = retrip_en;
    next_force_en   = force_en;
    next_force_stat = force_stat;
    next_pthr       = phase_pickup_threshold;
    next_rthr       = residual_pickup_threshold;
    next_retrip_dly = retrip_dly;
    next_fail_dly   = fail_dly;
    next_sig_mask   = sig_mask;
    next_relay_mask = relay_mask;
    rd_hit          = 1'b1;
    rd_val          = '0;
    if (paddr == OFF_CTRL) begin
      rd_val[CTRL_MODE_LSB +: 4]  = mode;
      rd_val[CTRL_RES_LSB +: 2]   = residual_source_select;
      rd_val[CTRL_RETRIP_BIT]     = retrip_en;
      rd_val[CTRL_FORCE_BIT]      = force_en;
      rd_val[CTRL_FSTAT_LSB +: 3] = force_stat;
      if (wr) begin
        next_mode       = mode_t'(pwdata[CTRL_MODE_LSB +: 4]);
        next_res_sel    = res_sel_t'(pwdata[CTRL_RES_LSB +: 2]);
        next_retrip_en  = pwdata[CTRL_RETRIP_BIT];
        next_force_en   = pwdata[CTRL_FORCE_BIT];
        next_force_stat = pwdata[CTRL_FSTAT_LSB +: 3];
      end
    end else if (paddr == OFF_PHASE_THR) begin
      rd_val[PTHR_W-1:0] = phase_pickup_threshold;
      if (wr) begin
        next_pthr = pwdata[PTHR_W-1:0];
      end
    end else if (paddr == OFF_RES_THR) begin
      rd_val[MAG_W-1:0] = residual_pickup_threshold;
      if (wr) begin
        next_rthr = pwdata[MAG_W-1:0];
      end
    end else if (paddr == OFF_RETRIP_DLY) begin
      rd_val[DLY_W-1:0] = retrip_dly;
      if (wr) begin
        next_retrip_dly = pwdata[DLY_W-1:0];
      end
    end else if (paddr == OFF_FAIL_DLY) begin
      rd_val[DLY_W-1:0] = fail_dly;
      if (wr) begin
        next_fail_dly = pwdata[DLY_W-1:0];
      end
    end else if (paddr == OFF_SIG_MASK) begin
      rd_val[SIG_W-1:0] = sig_mask;
      if (wr) begin
        next_sig_mask = pwdata[SIG_W-1:0];
      end
    end else if (paddr == OFF_RELAY_MASK) begin
      rd_val[RELAY_W-1:0] = relay_mask;
      if (wr) begin
        next_relay_mask = pwdata[RELAY_W-1:0];
      end
    end else if (paddr == OFF_STATUS) begin
      rd_val = stat_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_comb begin
    next_pready  = psel && penable && !pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rd_val;
      next_pslverr = !rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode                      <= MODE_CUR;
      residual_source_select    <= RES_UNUSED;
      retrip_en                 <= 1'b1;
      force_en                  <= 1'b0;
      force_stat                <= FORCE_NORMAL;
      phase_pickup_threshold    <= PTHR_RST;
      residual_pickup_threshold <= RTHR_RST;
      retrip_dly                <= RETRIP_RST;
      fail_dly                  <= FAIL_RST;
      sig_mask                  <= '0;
      relay_mask                <= '0;
      prdata                    <= 32'h0000_0000;
      pready                    <= 1'b0;
      pslverr                   <= 1'b0;
    end else begin
      mode                      <= next_mode;
      residual_source_select    <= next_res_sel;
      retrip_en                 <= next_retrip_en;
      force_en                  <= next_force_en;
      force_stat                <= next_force_stat;
      phase_pickup_threshold    <= next_pthr;
      residual_pickup_threshold <= next_rthr;
      retrip_dly                <= next_retrip_dly;
      fail_dly                  <= next_fail_dly;
      sig_mask                  <= next_sig_mask;
      relay_mask                <= next_relay_mask;
      prdata                    <= next_prdata;
      pready                    <= next_pready;
      pslverr                   <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pick-up comparators: channels 0..2 phases, 3 residual
  logic [MAG_W-1:0]  ch_mag [4];
  logic [MAG_W-1:0]  ch_thr [4];
  logic [3:0]        over;
  logic [3:0]        rel;
  logic [3:0]        next_pu;
  logic [MAG_W-1:0]  res_mag;
  logic [MAG_W-1:0]  pthr_m;

  assign pthr_m = MAG_W'(phase_pickup_threshold * PTHR_SCALE);

  always_comb begin
    case (residual_source_select)
      RES_ONE:  res_mag = residual_input_one;
      RES_TWO:  res_mag = residual_input_two;
      RES_CALC: res_mag = calculated_residual;
      default:  res_mag = '0;
    endcase
  end

  // magnitudes arrive already as fundamental-frequency values
  assign ch_mag[0] = phase_mag_a;
  assign ch_mag[1] = phase_mag_b;
  assign ch_mag[2] = phase_mag_c;
  assign ch_mag[3] = res_mag;
  assign ch_thr[0] = pthr_m;
  assign ch_thr[1] = pthr_m;
  assign ch_thr[2] = pthr_m;
  assign ch_thr[3] = residual_pickup_threshold;

  for (genvar i = 0; i < 4; i++) begin : g_cmp
    logic [PROD_W-1:0] mag_pct;
    logic [PROD_W-1:0] thr_pct;
    assign mag_pct = PROD_W'(ch_mag[i] * PCT_FULL);
    assign thr_pct = PROD_W'(ch_thr[i] * HYST_PCT);
    assign over[i] = ch_mag[i] > ch_thr[i];
    assign rel[i]  = mag_pct < thr_pct;
    always_comb begin
      if (i == 3 && residual_source_select == RES_UNUSED) begin
        next_pu[i] = 1'b0;
      end else if (over[i]) begin
        next_pu[i] = 1'b1;
      end else if (rel[i]) begin
        next_pu[i] = 1'b0;
      end else begin
        next_pu[i] = pu[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu <= '0;
    end else begin
      pu <= next_pu;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start condition per operating mode
  logic cur_c;
  logic do_c;
  logic sig_c;

  assign cur_c = |pu;
  assign do_c  = |(relay_controls & relay_mask);
  assign sig_c = |(trip_signals & sig_mask);

  always_comb begin
    case (mode)
      MODE_DO:                 start_cond = do_c;
      MODE_SIG:                start_cond = sig_c;
      MODE_CUR_AND_DO:         start_cond = cur_c && do_c;
      MODE_CUR_AND_SIG:        start_cond = cur_c && sig_c;
      MODE_CUR_OR_SIG:         start_cond = cur_c || sig_c;
      MODE_SIG_AND_DO:         start_cond = sig_c && do_c;
      MODE_SIG_OR_DO:          start_cond = sig_c || do_c;
      MODE_CUR_OR_DO:          start_cond = cur_c || do_c;
      MODE_CUR_OR_SIG_AND_DO:  start_cond = cur_c || (sig_c && do_c);
      MODE_CUR_OR_DO_OR_SIG:   start_cond = cur_c || do_c || sig_c;
      MODE_CUR_AND_DO_AND_SIG: start_cond = cur_c && do_c && sig_c;
      default:                 start_cond = cur_c;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // time base and delay counters
  // time base restarts with each start, so no delay output can come a tick early
  localparam int PRE_W = $clog2(TICK_CYC + 1);
  logic [PRE_W-1:0]  pre;
  logic [PRE_W-1:0]  next_pre;
  logic              tick;
  logic [DLY_W-1:0]  rt_cnt;
  logic [DLY_W-1:0]  fl_cnt;
  logic [DLY_W-1:0]  next_rt_cnt;
  logic [DLY_W-1:0]  next_fl_cnt;
  logic              rt_done;
  logic              fl_done;

  assign tick    = pre == PRE_W'(TICK_CYC - 1);
  assign rt_done = rt_cnt >= retrip_dly;
  assign fl_done = fl_cnt >= fail_dly;

  always_comb begin
    next_pre    = (tick || !start_cond) ? '0 : pre + 1'b1;
    next_rt_cnt = rt_cnt;
    next_fl_cnt = fl_cnt;
    if (!start_cond) begin
      next_rt_cnt = '0;
      next_fl_cnt = '0;
    end else if (tick) begin
      if (!rt_done) begin
        next_rt_cnt = rt_cnt + 1'b1;
      end
      if (!fl_done) begin
        next_fl_cnt = fl_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre    <= '0;
      rt_cnt <= '0;
      fl_cnt <= '0;
    end else begin
      pre    <= next_pre;
      rt_cnt <= next_rt_cnt;
      fl_cnt <= next_fl_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // function status and outputs
  state_t  next_state;
  logic    forced;

  assign forced = force_en && (force_stat != FORCE_NORMAL);

  always_comb begin
    if (force_en) begin
      case (force_stat)
        FORCE_START:   next_state = ST_START;
        FORCE_RETRIP:  next_state = ST_RETRIP;
        FORCE_FAIL:    next_state = ST_FAIL;
        FORCE_BLOCKED: next_state = ST_BLOCKED;
        default:       next_state = ST_NORMAL;
      endcase
    end else if (!start_cond) begin
      next_state = ST_NORMAL;
    end else if (fl_done) begin
      next_state = ST_FAIL;
    end else if (rt_done) begin
      next_state = ST_RETRIP;
    end else begin
      next_state = ST_START;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= ST_NORMAL;
      start_out              <= 1'b0;
      retrip_out             <= 1'b0;
      breaker_failure_output <= 1'b0;
      blocked_out            <= 1'b0;
    end else begin
      state                  <= next_state;
      start_out              <= next_state != ST_NORMAL && next_state != ST_BLOCKED;
      // retrip stays up alongside failure; gated off entirely when disabled
      retrip_out             <= retrip_en && (next_state == ST_RETRIP
                                || next_state == ST_FAIL);
      breaker_failure_output <= next_state == ST_FAIL;
      blocked_out            <= next_state == ST_BLOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_retrip_disabled: assert property (!retrip_en |=> !retrip_out)
    else $error("retrip output while retrip disabled");
  chk_fail_cause: assert property (
    breaker_failure_output |-> $past(start_cond) || $past(forced))
    else $error("breaker failure without start or force");
  chk_counter_clear: assert property (!start_cond |=> rt_cnt == '0 && fl_cnt == '0)
    else $error("delay counters not cleared");
  chk_pickup_release: assert property ($fell(pu[0]) |-> $past(rel[0]))
    else $error("phase pick-up released above hysteresis");
  chk_pickup_set: assert property (over[1] |=> pu[1])
    else $error("phase pick-up missed");
  chk_residual_unused: assert property (
    residual_source_select == RES_UNUSED |=> !pu[3])
    else $error("residual pick-up while unused");
  chk_fail_timing: assert property (
    !force_en && start_cond && fl_done ##1 start_cond |-> breaker_failure_output)
    else $error("breaker failure late");
  chk_force_block: assert property (
    force_en && force_stat == FORCE_BLOCKED |=> blocked_out && !breaker_failure_output)
    else $error("forced block not shown");
  chk_mode_signal: assert property (
    !force_en && mode == MODE_SIG && !sig_c |=> !start_out)
    else $error("start without selected signal");
  chk_apb_ready: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");

  cov_retrip: cover property (!retrip_out ##1 retrip_out);
  cov_fail: cover property ($rose(breaker_failure_output));
  cov_forced: cover property (forced ##2 blocked_out);
  cov_clear: cover property (start_out ##1 !start_cond ##1 !start_out);
endmodule
`default_nettype wire

// ---- tb/breaker_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module breaker_model
  import bfp_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [MAG_W-1:0] lvl_a,
  input  wire logic [MAG_W-1:0] lvl_b,
  input  wire logic [MAG_W-1:0] lvl_c,
  input  wire logic             opens_on_retrip,
  input  wire logic             retrip_out,
  output var  logic [MAG_W-1:0] mag_a,
  output var  logic [MAG_W-1:0] mag_b,
  output var  logic [MAG_W-1:0] mag_c
);
  logic opened;
  logic idle;
  assign idle = (lvl_a == '0) && (lvl_b == '0) && (lvl_c == '0);
  // a stuck breaker ignores the redundant coil, so the fault current keeps flowing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opened <= 1'b0;
    end else if (idle) begin
      opened <= 1'b0;
    end else if (retrip_out && opens_on_retrip) begin
      opened <= 1'b1;
    end
  end
  assign mag_a = opened ? '0 : lvl_a;
  assign mag_b = opened ? '0 : lvl_b;
  assign mag_c = opened ? '0 : lvl_c;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bfp_pkg::*;
  localparam int T = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, opens;
  logic        start_out, retrip_out, breaker_failure_output, blocked_out;
  logic [7:0]  paddr, relay_controls;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lvl_a, lvl_b, lvl_c, mag_a, mag_b, mag_c, rnd, trip_signals;
  logic [15:0] res_one, res_two, res_calc;
  logic [3:0]  fexp [5];
  int          n_fail, num_checks;
  breaker_failure_protection #(.TICK_CYC(T)) i_breaker_failure_protection (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_mag_a(mag_a), .phase_mag_b(mag_b), .phase_mag_c(mag_c),
    .residual_input_one(res_one), .residual_input_two(res_two),
    .calculated_residual(res_calc), .trip_signals(trip_signals),
    .relay_controls(relay_controls), .start_out(start_out), .retrip_out(retrip_out),
    .breaker_failure_output(breaker_failure_output), .blocked_out(blocked_out));
  breaker_model i_breaker_model (
    .pclk(pclk), .presetn(presetn), .lvl_a(lvl_a), .lvl_b(lvl_b), .lvl_c(lvl_c),
    .opens_on_retrip(opens), .retrip_out(retrip_out),
    .mag_a(mag_a), .mag_b(mag_b), .mag_c(mag_c));
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // waits are bounded so a dead slave cannot hang the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task set_lvl(input int p, input logic [15:0] v);
    lvl_a <= (p == 0) ? v : 16'h0000;
    lvl_b <= (p == 1) ? v : 16'h0000;
    lvl_c <= (p == 2) ? v : 16'h0000;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic ex(input int m, input logic c, input logic d, input logic s);
    case (m)
      1: return d;
      2: return s;
      3: return c & d;
      4: return c & s;
      5: return c | s;
      6: return s & d;
      7: return s | d;
      8: return c | d;
      9: return c | (s & d);
      10: return c | d | s;
      11: return c & d & s;
      default: return c;
    endcase
  endfunction
  task run_delay(input logic en, input logic op, input logic er, input logic ef);
    int tr;
    int tf;
    apb(1'b1, OFF_CTRL, en ? 32'h40 : 32'h0);
    opens <= op;
    set_lvl(0, 16'd1001);
    step(15);
    set_lvl(0, 16'h0000);
    step(4);
    chk("short_fault_clear", 0, {start_out, retrip_out});
    set_lvl(0, 16'd1001);
    tr = -1;
    tf = -1;
    for (int i = 1; i <= 80; i++) begin
      step(1);
      if (retrip_out === 1'b1 && tr < 0) tr = i;
      if (breaker_failure_output === 1'b1 && tf < 0) tf = i;
    end
    chk("retrip_time", 1, er ? (tr >= 2*T && tr <= 3*T+4) : (tr < 0));
    chk("fail_time", 1, ef ? (tf >= 5*T && tf <= 6*T+4) : (tf < 0));
    set_lvl(0, 16'h0000);
    step(5);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, opens} = '0;
    {paddr, pwdata, relay_controls, trip_signals} = '0;
    {lvl_a, lvl_b, lvl_c, res_one, res_two, res_calc} = '0;
    fexp = '{4'h0, 4'h8, 4'hC, 4'hE, 4'h1};
    rnd = 16'd3602;
    step(3);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4*i), 0);
      chk("reg_default", i==0 ? 32'h40 : i==1 ? 32'h14 : i==2 ? 32'h4B0 : i==3 ? 32'h14 : i==4 ? 32'h28 : 0, rd);
    end
    apb(1'b0, 8'h20, 0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, OFF_PHASE_THR, 32'd100);
    for (int p = 0; p < 3; p++) begin
      set_lvl(p, 16'd1000);
      step(4);
      chk("no_pickup_at_thr", 0, start_out);
      set_lvl(p, 16'd1001);
      step(4);
      chk("phase_start", 1, start_out);
      apb(1'b0, OFF_STATUS, 0);
      chk("status", 32'h202 | (32'h20 << p), rd);
      set_lvl(p, 16'd970);
      step(4);
      chk("hold_at_97", 1, start_out);
      set_lvl(p, 16'd969);
      step(4);
      chk("release", 0, start_out);
    end
    set_lvl(0, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFF_CTRL, 32'h40 | (s << 4));
      res_one <= (s < 2) ? 16'd1201 : 16'h0;
      res_two <= (s == 0 || s == 2) ? 16'd1201 : 16'h0;
      res_calc <= (s == 0 || s == 3) ? 16'd1201 : 16'h0;
      step(4);
      chk("residual_start", s != 0, start_out);
    end
    {res_one, res_two, res_calc} <= '0;
    apb(1'b1, OFF_SIG_MASK, 32'h0102);
    apb(1'b1, OFF_RELAY_MASK, 32'h10);
    for (int m = 0; m < 13; m++) begin
      apb(1'b1, OFF_CTRL, 32'h40 | m);
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        trip_signals <= rnd;
        relay_controls <= rnd[15:8];
        set_lvl(0, rnd[0] ? 16'd1001 : 16'h0);
        step(4);
        chk("mode_start", ex(m, rnd[0], rnd[12], |(rnd & 16'h0102)), start_out);
      end
    end
    set_lvl(0, 16'h0000);
    trip_signals <= '0;
    relay_controls <= '0;
    for (int f = 0; f < 5; f++) begin
      apb(1'b1, OFF_CTRL, 32'hC0 | (f << 8));
      step(3);
      chk("forced", fexp[f], {start_out, retrip_out, breaker_failure_output, blocked_out});
    end
    apb(1'b1, OFF_CTRL, 32'h340);
    step(3);
    chk("force_off", 0, {start_out, retrip_out, breaker_failure_output, blocked_out});
    apb(1'b1, OFF_RETRIP_DLY, 32'd2);
    apb(1'b1, OFF_FAIL_DLY, 32'd5);
    run_delay(1'b1, 1'b1, 1'b1, 1'b0);
    run_delay(1'b1, 1'b0, 1'b1, 1'b1);
    run_delay(1'b0, 1'b0, 1'b0, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
